//--- rtl/hsr_pkg.sv
// hsr_pkg: shared register map, bit weights and sizes for the service request block
package hsr_pkg;
	localparam int          ADDR_W          = 7;
	localparam int          DATA_W          = 8;
	localparam int          CHAN_W          = 3;
	localparam int          TX_DEPTH        = 8;
	localparam logic [6:0]  OFS_VEC         = 7'h40;
	localparam logic [6:0]  OFS_SCH1        = 7'h41;
	localparam logic [6:0]  OFS_SCH2        = 7'h42;
	localparam logic [6:0]  OFS_SCH3        = 7'h43;
	localparam logic [6:0]  OFS_MCHG        = 7'h12;
	localparam logic [6:0]  OFS_MSMV        = 7'h61;
	localparam logic [6:0]  OFS_TSMV        = 7'h62;
	localparam logic [6:0]  OFS_RSMV        = 7'h63;
	localparam logic [6:0]  OFS_CSEL        = 7'h64;
	localparam logic [6:0]  OFS_PEND        = 7'h65;
	localparam logic [6:0]  OFS_RCFG        = 7'h66;
	localparam logic [6:0]  OFS_FREV        = 7'h6B;
	localparam logic [6:0]  OFS_PPH         = 7'h70;
	localparam logic [6:0]  OFS_PPL         = 7'h71;
	localparam logic [6:0]  OFS_MACK        = 7'h75;
	localparam logic [6:0]  OFS_TACK        = 7'h76;
	localparam logic [6:0]  OFS_RACK        = 7'h77;
	localparam logic [6:0]  OFS_TXD         = 7'h7B;
	localparam logic [6:0]  OFS_EOS         = 7'h7F;
	localparam logic [7:0]  RST_VEC         = 8'hFF;
	localparam logic [7:0]  RST_PP          = 8'hFF;
	localparam logic [7:0]  RST_ACK         = 8'h80;
	localparam logic [7:0]  RST_ZERO       = 8'h00;
	localparam logic [7:0]  PEND_RX         = 8'h10;
	localparam logic [7:0]  PEND_TX         = 8'h04;
	localparam logic [7:0]  PEND_MDM        = 8'h02;
	localparam logic [7:0]  MCHG_CTS        = 8'h20;
	localparam logic [7:0]  MCHG_CD         = 8'h40;
	localparam logic [7:0]  MCHG_DSR        = 8'h80;
	localparam int          CHAN_LSB        = 2;
	localparam logic [7:0]  FREV_ARB        = 8'h5A; // arbitrary value
	localparam logic [1:0]  VEC_MDM         = 2'h1;
	localparam logic [1:0]  VEC_TX          = 2'h2;
	localparam logic [1:0]  VEC_RX          = 2'h3;
	localparam logic [7:0]  EOS_VALUE       = 8'h00;
	localparam logic [7:0]  MCHG_CLEAR      = 8'h00;
	localparam int          CLS_RX          = 0;
	localparam int          CLS_TX          = 1;
	localparam int          CLS_MDM         = 2;
	localparam int          N_CLS           = 3;
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_SETUP = 4'b0010,
		HS_RUN = 4'b0100,
		HS_DONE = 4'b1000
	} hsr_hstate_t;
endpackage : hsr_pkg

//--- rtl/hsr_if.sv
// hsr_if: parallel register bus between host and the service request device
`timescale 1ns/100ps
`default_nettype none
interface hsr_if;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rd;
	logic       wr;
	logic       ack_in;
	logic       irq;
	modport dev  (input addr, input wdata, input rd, input wr, input ack_in, output rdata, output irq);
	modport host (output addr, output wdata, output rd, output wr, output ack_in, input rdata, input irq);
endinterface : hsr_if
`default_nettype wire

//--- rtl/hsr_tx_buf.sv
// hsr_tx_buf: per-context transmit character buffer with write count
`timescale 1ns/100ps
`default_nettype none
module hsr_tx_buf #(
	parameter int DEPTH = 8,
	parameter int W     = 8
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         clr,
	input  wire logic         push,
	input  wire logic [W-1:0] din,
	output logic              full,
	output logic [3:0]        count,
	output logic [W-1:0]      last
);
	typedef struct packed {
		logic [3:0]   cnt;
		logic [W-1:0] last;
	} hsr_buf_st_t;
	logic [W-1:0] mem [DEPTH];
	hsr_buf_st_t  st_r;
	hsr_buf_st_t  st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (clr) begin
			st_nxt.cnt = '0;
		end else if (push && !full) begin
			st_nxt.cnt  = st_r.cnt + 4'h1;
			st_nxt.last = din;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// storage has no reset; only count marks valid entries
	always_ff @(posedge clk) begin
		if (push && !full && !clr) begin
			mem[st_r.cnt[2:0]] <= din;
		end
	end
	assign full  = (st_r.cnt == 4'(DEPTH));
	assign count = st_r.cnt;
	assign last  = st_r.last;
endmodule : hsr_tx_buf
`default_nettype wire

//--- rtl/hsr_dev.sv
// hsr_dev: device end: pending flags, acknowledge decode, service context, registers
// Operation
// - host programs match values before polling
// - polled read of match register acknowledges class
// - pending flags rx 0x10, tx 0x04, modem 0x02
// - channel number in service channel bits 4:2
// - up to eight transmit writes per context
// - end-of-service write closes the context
// - modem change flags cts, cd, dsr upper bits
// - host clears modem change flags before ending
// - modem soft acknowledge read enters modem context
// - polled and interrupt servicing may mix
// - hardware acknowledge address equals match value
`timescale 1ns/100ps
`default_nettype none
module hsr_dev #(
	parameter int TX_DEPTH = hsr_pkg::TX_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	hsr_if.dev              bus,
	input  wire logic [2:0] req_valid,
	input  wire logic [2:0] req_chan_rx,
	input  wire logic [2:0] req_chan_tx,
	input  wire logic [2:0] req_chan_mdm,
	input  wire logic [2:0] mdm_change,
	output logic [2:0]      req_taken,
	output logic            tx_push,
	output logic [7:0]      tx_char,
	output logic [2:0]      tx_chan,
	output logic [3:0]      tx_count
);
	typedef struct packed {
		logic [7:0] vec;
		logic [7:0] sch2;
		logic [7:0] sch3;
		logic [7:0] msmv;
		logic [7:0] tsmv;
		logic [7:0] rsmv;
		logic [7:0] csel;
		logic [7:0] rcfg;
		logic [7:0] pph;
		logic [7:0] ppl;
		logic [7:0] mchg;
		logic       active;
		logic [1:0] cls;
		logic [2:0] chan;
		logic [7:0] rdata;
		logic       txp;
		logic [7:0] txc;
	} hsr_dev_st_t;
	hsr_dev_st_t st_r;
	hsr_dev_st_t st_nxt;
	logic        buf_full;
	logic [7:0]  pend;
	logic [2:0]  sel;
	logic [2:0]  sel_chan;
	logic        ack_mdm;
	logic        ack_tx;
	logic        ack_rx;
	logic        any_ack;
	logic [1:0]  ack_cls;
	logic        wr_tx;
	logic        wr_eos;
	logic [7:0]  gsc1;
	logic [7:0]  rd_mux;
	// only one class is presented at a time, rx first, so acknowledges stay unambiguous
	always_comb begin
		sel = 3'b000;
		if (st_r.active) begin
			sel = 3'b000;
		end else if (req_valid[hsr_pkg::CLS_RX]) begin
			sel[hsr_pkg::CLS_RX] = 1'b1;
		end else if (req_valid[hsr_pkg::CLS_TX]) begin
			sel[hsr_pkg::CLS_TX] = 1'b1;
		end else if (req_valid[hsr_pkg::CLS_MDM]) begin
			sel[hsr_pkg::CLS_MDM] = 1'b1;
		end
	end
	always_comb begin
		pend = 8'h00;
		if (st_r.active) begin
			unique case (st_r.cls)
				hsr_pkg::VEC_RX:  pend = hsr_pkg::PEND_RX;
				hsr_pkg::VEC_TX:  pend = hsr_pkg::PEND_TX;
				default:          pend = hsr_pkg::PEND_MDM;
			endcase
		end else begin
			pend = (sel[hsr_pkg::CLS_RX] ? hsr_pkg::PEND_RX : 8'h00)
			     | (sel[hsr_pkg::CLS_TX] ? hsr_pkg::PEND_TX : 8'h00)
			     | (sel[hsr_pkg::CLS_MDM] ? hsr_pkg::PEND_MDM : 8'h00);
		end
	end
	// hardware ack: ack_in read at match address; polled: plain read of match register
	assign ack_mdm = bus.rd && sel[hsr_pkg::CLS_MDM] &&
		((bus.ack_in && bus.addr == st_r.msmv[6:0]) ||
		 (!bus.ack_in && (bus.addr == hsr_pkg::OFS_MSMV || bus.addr == hsr_pkg::OFS_MACK)));
	assign ack_tx = bus.rd && sel[hsr_pkg::CLS_TX] &&
		((bus.ack_in && bus.addr == st_r.tsmv[6:0]) ||
		 (!bus.ack_in && (bus.addr == hsr_pkg::OFS_TSMV || bus.addr == hsr_pkg::OFS_TACK)));
	assign ack_rx = bus.rd && sel[hsr_pkg::CLS_RX] &&
		((bus.ack_in && bus.addr == st_r.rsmv[6:0]) ||
		 (!bus.ack_in && (bus.addr == hsr_pkg::OFS_RSMV || bus.addr == hsr_pkg::OFS_RACK)));
	assign any_ack  = ack_mdm || ack_tx || ack_rx;
	assign ack_cls  = ack_rx ? hsr_pkg::VEC_RX : (ack_tx ? hsr_pkg::VEC_TX : hsr_pkg::VEC_MDM);
	assign sel_chan = sel[hsr_pkg::CLS_RX] ? req_chan_rx : (sel[hsr_pkg::CLS_TX] ? req_chan_tx : req_chan_mdm);
	assign wr_tx  = bus.wr && bus.addr == hsr_pkg::OFS_TXD && st_r.active && st_r.cls == hsr_pkg::VEC_TX;
	assign wr_eos = bus.wr && bus.addr == hsr_pkg::OFS_EOS && st_r.active;
	assign gsc1   = 8'(st_r.chan) << hsr_pkg::CHAN_LSB;
	always_comb begin
		unique case (bus.addr)
			hsr_pkg::OFS_VEC:   rd_mux = st_r.vec;
			hsr_pkg::OFS_SCH1:  rd_mux = st_r.active ? gsc1 : 8'h00;
			hsr_pkg::OFS_SCH2:  rd_mux = st_r.sch2;
			hsr_pkg::OFS_SCH3:  rd_mux = st_r.sch3;
			hsr_pkg::OFS_MSMV:  rd_mux = st_r.msmv;
			hsr_pkg::OFS_TSMV:  rd_mux = st_r.tsmv;
			hsr_pkg::OFS_RSMV:  rd_mux = st_r.rsmv;
			hsr_pkg::OFS_CSEL:  rd_mux = st_r.csel;
			hsr_pkg::OFS_PEND:  rd_mux = pend;
			hsr_pkg::OFS_RCFG:  rd_mux = st_r.rcfg;
			hsr_pkg::OFS_FREV:  rd_mux = hsr_pkg::FREV_ARB;
			hsr_pkg::OFS_PPH:   rd_mux = st_r.pph;
			hsr_pkg::OFS_PPL:   rd_mux = st_r.ppl;
			hsr_pkg::OFS_MCHG:  rd_mux = st_r.mchg;
			hsr_pkg::OFS_MACK,
			hsr_pkg::OFS_TACK,
			hsr_pkg::OFS_RACK:  rd_mux = hsr_pkg::RST_ACK; // idle value when no class is presented
			default:            rd_mux = 8'h00;
		endcase
		// the acknowledge read returns the vector with the class code in bits 1:0
		if (any_ack) begin
			rd_mux = {st_r.vec[7:2], ack_cls};
		end
	end
	always_comb begin
		st_nxt     = st_r;
		st_nxt.txp = 1'b0;
		if (bus.rd) begin
			st_nxt.rdata = rd_mux;
		end
		if (bus.wr && !bus.ack_in) begin
			unique case (bus.addr)
				hsr_pkg::OFS_VEC:   st_nxt.vec   = bus.wdata;
				hsr_pkg::OFS_SCH2:  st_nxt.sch2  = bus.wdata;
				hsr_pkg::OFS_SCH3:  st_nxt.sch3  = bus.wdata;
				hsr_pkg::OFS_MSMV:  st_nxt.msmv  = bus.wdata;
				hsr_pkg::OFS_TSMV:  st_nxt.tsmv  = bus.wdata;
				hsr_pkg::OFS_RSMV:  st_nxt.rsmv  = bus.wdata;
				hsr_pkg::OFS_CSEL:  st_nxt.csel  = bus.wdata;
				hsr_pkg::OFS_RCFG:  st_nxt.rcfg  = bus.wdata;
				hsr_pkg::OFS_PPH:   st_nxt.pph   = bus.wdata;
				hsr_pkg::OFS_PPL:   st_nxt.ppl   = bus.wdata;
				hsr_pkg::OFS_MCHG:  st_nxt.mchg  = bus.wdata;
				default:            st_nxt.vec   = st_r.vec;
			endcase
		end
		// change events set the flags; set wins over a same-cycle clear
		if (mdm_change[0]) st_nxt.mchg = st_nxt.mchg | hsr_pkg::MCHG_CTS;
		if (mdm_change[1]) st_nxt.mchg = st_nxt.mchg | hsr_pkg::MCHG_CD;
		if (mdm_change[2]) st_nxt.mchg = st_nxt.mchg | hsr_pkg::MCHG_DSR;
		if (any_ack) begin
			st_nxt.active = 1'b1;
			st_nxt.cls    = ack_cls;
			st_nxt.chan   = sel_chan;
		end
		if (wr_tx && !buf_full) begin
			st_nxt.txp = 1'b1;
			st_nxt.txc = bus.wdata;
		end
		if (wr_eos) begin
			st_nxt.active = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r       <= '0;
			st_r.vec   <= hsr_pkg::RST_VEC;
			st_r.pph   <= hsr_pkg::RST_PP;
			st_r.ppl   <= hsr_pkg::RST_PP;
		end else begin
			st_r <= st_nxt;
		end
	end
	hsr_tx_buf #(.DEPTH(TX_DEPTH), .W(hsr_pkg::DATA_W)) u_buf (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clr     (wr_eos),
		.push    (wr_tx),
		.din     (bus.wdata),
		.full    (buf_full),
		.count   (tx_count),
		.last    ()
	);
	assign bus.rdata = st_r.rdata;
	assign bus.irq   = |pend && !st_r.active;
	assign req_taken = {ack_mdm, ack_tx, ack_rx};
	assign tx_push   = st_r.txp;
	assign tx_char   = st_r.txc;
	assign tx_chan   = st_r.chan;
endmodule : hsr_dev
`default_nettype wire

//--- rtl/hsr_host.sv
// hsr_host: host end: programs match values, polls, acknowledges and ends service
`timescale 1ns/100ps
`default_nettype none
module hsr_host (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	hsr_if.host             bus,
	input  wire logic       start,
	input  wire logic       use_hw_ack,
	input  wire logic [7:0] tx_byte,
	input  wire logic [3:0] tx_len,
	output logic            busy,
	output logic [7:0]      last_vector,
	output logic [2:0]      last_chan
);
	typedef enum logic [3:0] {
		SQ_INIT = 4'b0001,
		SQ_POLL = 4'b0010,
		SQ_SERV = 4'b0100,
		SQ_END  = 4'b1000
	} hsr_sq_t;
	typedef struct packed {
		hsr_sq_t    sq;
		logic [2:0] step;
		logic [3:0] n;
		logic [7:0] pend;
		logic [7:0] vec;
		logic [2:0] chan;
		logic       go;
	} hsr_host_st_t;
	hsr_host_st_t st_r;
	hsr_host_st_t st_nxt;
	always_comb begin
		st_nxt    = st_r;
		bus.rd    = 1'b0;
		bus.wr    = 1'b0;
		bus.ack_in = 1'b0;
		bus.addr  = 7'h00;
		bus.wdata = 8'h00;
		if (start) st_nxt.go = 1'b1;
		unique case (st_r.sq)
			SQ_INIT: begin
				bus.wr = 1'b1;
				st_nxt.step = st_r.step + 3'h1;
				unique case (st_r.step)
					3'h0: begin bus.addr = hsr_pkg::OFS_RSMV; bus.wdata = {1'b0, hsr_pkg::OFS_RSMV}; end
					3'h1: begin bus.addr = hsr_pkg::OFS_TSMV; bus.wdata = {1'b0, hsr_pkg::OFS_TSMV}; end
					default: begin
						bus.addr = hsr_pkg::OFS_MSMV;
						bus.wdata = {1'b0, hsr_pkg::OFS_MSMV};
						st_nxt.sq = SQ_POLL;
						st_nxt.step = 3'h0;
					end
				endcase
			end
			SQ_POLL: begin
				if (st_r.go) begin
					bus.rd = 1'b1;
					bus.addr = hsr_pkg::OFS_PEND;
					if (st_r.step == 3'h0) begin
						st_nxt.step = 3'h1;
					end else begin
						st_nxt.pend = bus.rdata;
						st_nxt.step = 3'h0;
						if (|(bus.rdata & (hsr_pkg::PEND_RX | hsr_pkg::PEND_TX | hsr_pkg::PEND_MDM))) begin
							st_nxt.sq = SQ_SERV;
							bus.rd = 1'b0;
						end
					end
				end
			end
			SQ_SERV: begin
				st_nxt.step = st_r.step + 3'h1;
				unique case (st_r.step)
					3'h0: begin
						bus.rd = 1'b1;
						bus.ack_in = use_hw_ack;
						if (st_r.pend[4]) bus.addr = hsr_pkg::OFS_RSMV;
						else if (st_r.pend[2]) bus.addr = hsr_pkg::OFS_TSMV;
						else bus.addr = use_hw_ack ? hsr_pkg::OFS_MSMV : hsr_pkg::OFS_MACK;
					end
					3'h1: begin
						// the acknowledge read's vector stands in this cycle only until the next read
						st_nxt.vec = bus.rdata;
						bus.rd = 1'b1;
						bus.addr = hsr_pkg::OFS_SCH1;
					end
					3'h2: begin
						st_nxt.chan = bus.rdata[hsr_pkg::CHAN_LSB +: hsr_pkg::CHAN_W];
						bus.rd = 1'b1;
						// modem service looks at the change flags before clearing them
						bus.addr = (st_r.pend[1] && !st_r.pend[2] && !st_r.pend[4]) ?
							hsr_pkg::OFS_MCHG : hsr_pkg::OFS_SCH1;
						st_nxt.n = 4'h0;
					end
					3'h3: begin
						st_nxt.step = 3'h3;
						if (st_r.pend[2] && !st_r.pend[4] && st_r.n < tx_len && st_r.n < 4'(hsr_pkg::TX_DEPTH)) begin
							bus.wr = 1'b1;
							bus.addr = hsr_pkg::OFS_TXD;
							bus.wdata = tx_byte;
							st_nxt.n = st_r.n + 4'h1;
						end else if (st_r.pend[1] && !st_r.pend[2] && !st_r.pend[4]) begin
							bus.wr = 1'b1;
							bus.addr = hsr_pkg::OFS_MCHG;
							bus.wdata = hsr_pkg::MCHG_CLEAR;
							st_nxt.sq = SQ_END;
						end else begin
							st_nxt.sq = SQ_END;
						end
					end
					default: st_nxt.step = 3'h0;
				endcase
			end
			SQ_END: begin
				bus.wr = 1'b1;
				bus.addr = hsr_pkg::OFS_EOS;
				bus.wdata = hsr_pkg::EOS_VALUE;
				st_nxt.sq = SQ_POLL;
				st_nxt.step = 3'h0;
				st_nxt.go = start;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r    <= '0;
			st_r.sq <= SQ_INIT;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign busy        = st_r.sq != SQ_POLL;
	assign last_vector = st_r.vec;
	assign last_chan   = st_r.chan;
endmodule : hsr_host
`default_nettype wire

//--- tb/hsr_properties.sv
// hsr_properties: concurrent checks on the host to device register bus
`timescale 1ns/100ps
`default_nettype none
module hsr_properties (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rd,
	input wire logic       wr,
	input wire logic       ack_in,
	input wire logic       irq
);
	logic       irq_d_r;
	logic       ctx_r;
	logic [3:0] ntx_r;
	wire logic  eos;
	wire logic  txw;
	assign eos = wr && addr == hsr_pkg::OFS_EOS;
	assign txw = wr && addr == hsr_pkg::OFS_TXD;
	// context is inferred from irq falling; a request withdrawn before its acknowledge would confuse it
	always_ff @(posedge clk) begin
		irq_d_r <= sys_rst ? 1'b0 : irq;
		if (sys_rst || eos) begin
			ctx_r <= 1'b0;
			ntx_r <= 4'h0;
		end else begin
			ctx_r <= ctx_r | (irq_d_r & ~irq);
			ntx_r <= ntx_r + {3'h0, txw};
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_ack;
		irq && rd ##1 !irq;
	endsequence
	a_chan_field: assert property (rd && addr == hsr_pkg::OFS_SCH1 |=> rdata[1:0] == 2'h0 && rdata[7:5] == 3'h0)
		else $error("channel register has bits outside the channel field");
	a_pend_bits: assert property (rd && addr == hsr_pkg::OFS_PEND |=> (rdata & 8'hE9) == 8'h00)
		else $error("pending flags outside the three class bits");
	a_mchg_bits: assert property (rd && addr == hsr_pkg::OFS_MCHG |=> rdata[4:0] == 5'h00)
		else $error("modem change flags outside the upper three bits");
	a_ack_code: assert property (s_ack |-> rdata[1:0] != 2'h0)
		else $error("acknowledge read gave no class code");
	a_ack_then_eos: assert property (s_ack |-> ##[1:200] eos)
		else $error("service context not ended by end of service write");
	a_ctx_quiet: assert property (ctx_r |-> !irq)
		else $error("request presented inside a service context");
	a_rdata_hold: assert property (!rd |=> $stable(rdata))
		else $error("read data changed without a read");
	a_tx_in_ctx: assert property (txw |-> ctx_r)
		else $error("transmit write outside a service context");
	a_tx_limit: assert property (txw |-> ntx_r < 4'h8)
		else $error("more than eight transmit writes in one context");
endmodule : hsr_properties
`default_nettype wire

//--- tb/testbench.sv
// testbench: host and device ends on one bus, a second device driven directly
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [1:0] cls;
		logic [2:0] chan;
		logic       hw;
		logic [3:0] len;
		logic [7:0] chr;
	} hsr_row_t;
	logic       clk, sys_rst, start, use_hw_ack, busy;
	logic [7:0] tx_byte, last_vector, tx_char, tx_char_b;
	logic [3:0] tx_len, tx_count, tx_count_b;
	logic [2:0] last_chan, rq_chan, req_valid, mdm_change, req_taken, tx_chan;
	logic [2:0] req_valid_b, mdm_change_b, req_taken_b, tx_chan_b, taken_b;
	logic       tx_push, tx_push_b;
	int         n_mismatch, checks, n_push, n_push_b, i;
	hsr_row_t   rows [6] = '{'{2'h0, 3'h5, 1'b0, 4'h0, 8'h00}, '{2'h1, 3'h3, 1'b1, 4'h8, 8'hA5},
		'{2'h2, 3'h7, 1'b0, 4'h0, 8'h00}, '{2'h0, 3'h0, 1'b1, 4'h0, 8'h00},
		'{2'h1, 3'h6, 1'b0, 4'h9, 8'h3C}, '{2'h2, 3'h1, 1'b1, 4'h0, 8'h00}};
	logic [6:0] def_a [11] = '{7'h40, 7'h41, 7'h42, 7'h61, 7'h62, 7'h63, 7'h65, 7'h70, 7'h75, 7'h77, 7'h00};
	logic [7:0] def_v [11] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h80, 8'h80, 8'h00};
	hsr_if bus_a();
	hsr_if bus_b();
	hsr_host hsr_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_a.host), .start(start), .use_hw_ack(use_hw_ack),
		.tx_byte(tx_byte), .tx_len(tx_len), .busy(busy), .last_vector(last_vector), .last_chan(last_chan));
	hsr_dev hsr_dev_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_a.dev), .req_valid(req_valid), .req_chan_rx(rq_chan),
		.req_chan_tx(rq_chan), .req_chan_mdm(rq_chan), .mdm_change(mdm_change), .req_taken(req_taken),
		.tx_push(tx_push), .tx_char(tx_char), .tx_chan(tx_chan), .tx_count(tx_count));
	hsr_dev hsr_dev_inst_b (.clk(clk), .sys_rst(sys_rst), .bus(bus_b.dev), .req_valid(req_valid_b),
		.req_chan_rx(3'h2), .req_chan_tx(3'h4), .req_chan_mdm(3'h1), .mdm_change(mdm_change_b),
		.req_taken(req_taken_b), .tx_push(tx_push_b), .tx_char(tx_char_b), .tx_chan(tx_chan_b), .tx_count(tx_count_b));
	hsr_properties hsr_properties_inst (.clk(clk), .sys_rst(sys_rst), .addr(bus_a.addr), .wdata(bus_a.wdata),
		.rdata(bus_a.rdata), .rd(bus_a.rd), .wr(bus_a.wr), .ack_in(bus_a.ack_in), .irq(bus_a.irq));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// pushes are checked as they land; channel and character must match the serviced context
	always @(posedge clk) begin
		if (tx_push === 1'b1) begin
			n_push++;
			chk("tx char", tx_byte, tx_char);
			chk("tx chan", {5'h0, rq_chan}, {5'h0, tx_chan});
		end
		if (tx_push_b === 1'b1) begin
			chk("tx char b", 8'h30 + 8'(n_push_b), tx_char_b);
			chk("tx chan b", 8'h04, {5'h0, tx_chan_b});
			n_push_b++;
		end
		if (req_taken_b !== 3'h0) taken_b = taken_b | req_taken_b;
	end
	task automatic bw(input logic [6:0] a, input logic [7:0] v);
		bus_b.addr = a;
		bus_b.wdata = v;
		bus_b.wr = 1'b1;
		@(negedge clk);
		bus_b.wr = 1'b0;
		@(negedge clk);
	endtask : bw
	task automatic rc(input logic [6:0] a, input logic [7:0] e, input string what);
		bus_b.addr = a;
		bus_b.rd = 1'b1;
		@(negedge clk);
		bus_b.rd = 1'b0;
		chk(what, e, bus_b.rdata);
		@(negedge clk);
	endtask : rc
	// bounded wait at mid cycle, so a one cycle combinational pulse is seen settled
	task automatic wait_for(input int sel, input logic [1:0] c);
		int k;
		for (k = 0; k < 400 && (sel ? busy !== 1'b0 : req_taken[c] !== 1'b1); k++) @(negedge clk);
		if (k == 400) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : wait_for
	task automatic run_row(input hsr_row_t r);
		int p0;
		p0 = n_push;
		use_hw_ack = r.hw;
		tx_len = r.len;
		tx_byte = r.chr;
		rq_chan = r.chan;
		req_valid = 3'h1 << r.cls;
		mdm_change = (r.cls == 2'h2) ? 3'h4 : 3'h0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		mdm_change = 3'h0;
		wait_for(0, r.cls);
		// the request must still stand at the edge that takes the acknowledge
		@(negedge clk);
		req_valid = 3'h0;
		wait_for(1, r.cls);
		chk("tx count", 8'h0, {4'h0, tx_count});
		chk("vector", {6'h3F, r.cls == 2'h0 ? hsr_pkg::VEC_RX : r.cls == 2'h1 ? hsr_pkg::VEC_TX : hsr_pkg::VEC_MDM},
			last_vector);
		chk("channel", {5'h0, r.chan}, {5'h0, last_chan});
		chk("pushes", (r.cls == 2'h1) ? ((r.len > 4'h8) ? 8'h8 : {4'h0, r.len}) : 8'h0, 8'(n_push - p0));
	endtask : run_row
	initial begin
		{start, use_hw_ack, tx_byte, tx_len, rq_chan, req_valid, mdm_change, req_valid_b, mdm_change_b} = '0;
		{bus_b.addr, bus_b.wdata, bus_b.rd, bus_b.wr, bus_b.ack_in, taken_b} = '0;
		sys_rst = 1'b1;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		wait_for(1, 2'h0);
		for (i = 0; i < 6; i++) run_row(rows[i]);
		$display("test rows done");
		for (i = 0; i < 11; i++) rc(def_a[i], def_v[i], "default");
		rc(7'h6B, hsr_pkg::FREV_ARB, "revision");
		$display("test defaults done");
		bw(7'h63, 8'h8A);
		bus_b.ack_in = 1'b1;
		bw(7'h63, 8'h11);
		bus_b.ack_in = 1'b0;
		rc(7'h63, 8'h8A, "match kept");
		req_valid_b = 3'h3;
		bw(7'h7B, 8'h55);
		bus_b.ack_in = 1'b1;
		rc(7'h0A, 8'hFF, "rx vector");
		bus_b.ack_in = 1'b0;
		req_valid_b = 3'h2;
		chk("rx taken", 8'h01, {5'h0, taken_b});
		chk("irq in context", 8'h0, {7'h0, bus_b.irq});
		rc(7'h41, 8'h08, "rx channel");
		bw(7'h7B, 8'h55);
		chk("refused push", 8'h0, 8'(n_push_b));
		bw(7'h7F, 8'h00);
		rc(7'h62, 8'hFE, "tx vector");
		req_valid_b = 3'h0;
		rc(7'h41, 8'h10, "tx channel");
		for (i = 0; i < 9; i++) bw(7'h7B, 8'h30 + 8'(i));
		chk("tx pushes", 8'h8, 8'(n_push_b));
		chk("tx count", 8'h8, {4'h0, tx_count_b});
		bw(7'h7F, 8'h00);
		rc(7'h41, 8'h00, "idle channel");
		$display("test rx tx done");
		for (i = 0; i < 3; i++) begin
			mdm_change_b = 3'h1 << i;
			req_valid_b = 3'h4;
			@(negedge clk);
			mdm_change_b = 3'h0;
			rc(7'h65, 8'h02, "pending modem");
			rc(7'h75, 8'hFD, "modem vector");
			req_valid_b = 3'h0;
			rc(7'h12, 8'h20 << i, "modem change");
			bw(7'h12, 8'h00);
			rc(7'h12, 8'h00, "modem cleared");
			bw(7'h7F, 8'h00);
		end
		$display("test modem done");
		bw(7'h40, 8'h00);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rc(7'h40, 8'hFF, "vector after reset");
		$display("test reset done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
